// *** rtl/isd_regs.svh ***
// Purpose: Constants for the interface strobe decoder.
// Assumes: 100 MHz system clock, 1 MHz conversion clock.
// Notes: Behaviour list follows.
// Behaviour
// [RULE1] Separate strobe per analog sub-assembly.
// [RULE2] Frequency-control strobe has extra qualifier enable.
// [RULE3] Wait about 2 us before decoder enable.
// [RULE4] Delay counted on conversion clock only.
// [RULE5] First decoder uses select bits 1..3.
// [RULE6] Second decoder uses select bits 0..2.
// [RULE7] Buffer address and data onto cable.
// [RULE8] One strobe pulse per sub-assembly write.
// [RULE9] Controller supplies 1 MHz conversion clock.
// [RULE10] Enabled decoder drives only selected output low.
// [RULE11] Two conversion edges delay; release on request fall.
`ifndef ISD_REGS_SVH
`define ISD_REGS_SVH
`define ISD_ENA_DELAY_US 2
`define ISD_CONV_CLK_MHZ 1
`define ISD_ENA_EDGES (`ISD_ENA_DELAY_US * `ISD_CONV_CLK_MHZ)
`define ISD_SUB_RF 2'h0
`define ISD_SUB_FC 2'h1
`define ISD_SUB_IF 2'h2
`define ISD_SUB_LOG 2'h3
`endif

// *** rtl/isd_pkg.sv ***
// Purpose: Types for the interface strobe decoder.
// Assumes: Included constants header holds the numbers.
// Notes: One-hot delay states.
package isd_pkg;
   typedef enum logic [2:0] {
      ISD_IDLE = 3'h1,
      ISD_WAIT = 3'h2,
      ISD_ENA = 3'h4
   } isd_state_t;
   typedef logic [7:0] isd_byte_t;
endpackage

// *** rtl/isd_dec3to8.sv ***
// Purpose: Active-low 3-to-8 decoder with active-low enable.
// Assumes: Select is steady while enabled.
// Notes: Outputs registered so glitches never reach the cable.
`timescale 1ns/1ps
module isd_dec3to8 (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic enable_n,
   input wire logic [2:0] sel,
   output logic [7:0] out_n
);
   // [RULE10] One low output when enabled; all high otherwise or in reset.
   always_ff @(posedge clk_sys) begin
      if (!rst_b || enable_n) begin
         out_n <= 8'hff;
      end else begin
         out_n <= ~(8'h01 << sel);
      end
   end
endmodule

// *** rtl/isd_strobe_decoder.sv ***
// Purpose: Analog-bus strobe timing and on-board strobe select decoding.
// Assumes: All inputs synchronous to clk_sys; conversion clock sampled as a level.
// Notes: Strobes are registered and active low, except the active-high counter loads.
`timescale 1ns/1ps
`include "isd_regs.svh"
module isd_strobe_decoder #(
   parameter int ENA_EDGES = `ISD_ENA_EDGES
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic analog_bus_request,
   input wire logic conversion_clock_1mhz,
   input wire logic [1:0] analog_target,
   input wire logic iface_strobe_req,
   input wire logic iface_bank_sel,
   input wire logic iface_select_bit0,
   input wire logic iface_select_bit1,
   input wire logic iface_select_bit2,
   input wire logic iface_select_bit3,
   input wire isd_pkg::isd_byte_t ctrl_addr,
   input wire isd_pkg::isd_byte_t ctrl_data,
   output isd_pkg::isd_byte_t cable_addr,
   output isd_pkg::isd_byte_t cable_data,
   output logic rf_assembly_strobe_n,
   output logic freq_ctrl_assembly_strobe_n,
   output logic if_assembly_strobe_n,
   output logic logamp_assembly_strobe_n,
   output logic freq_ctrl_strobe_qualifier,
   output logic keypad_scan_strobe_n,
   output logic converter_load1_n,
   output logic converter_load2_n,
   output logic converter_load3_n,
   output logic sampler_reg1_strobe_n,
   output logic keypad_sense_strobe_n,
   output logic irq_priority_read_n,
   output logic sampler_data1_read_n,
   output logic converter_data0_strobe_n,
   output logic counter_load0,
   output logic counter_load1,
   output logic knob_read_n,
   output logic sampler_reg0_strobe_n
);
   import isd_pkg::*;

   isd_state_t state_r;
   logic conv_d_r;
   logic req_d_r;
   logic [7:0] edge_cnt_r;
   logic conv_rise;
   logic req_fall;
   logic last_edge;
   logic sub_ena_n;
   logic [2:0] sub_sel;
   logic [7:0] sub_dec_n;
   logic dec1_ena_n;
   logic dec2_ena_n;
   logic [2:0] dec1_sel;
   logic [2:0] dec2_sel;
   logic [7:0] dec1_n;
   logic [7:0] dec2_n;

   // Packs three separate select pins into a decoder code, first argument most significant.
   // Both on-board decoders share the middle pins, so one helper keeps their order consistent.
   function automatic logic [2:0] pack_sel(
      input logic b_hi,
      input logic b_mid,
      input logic b_lo
   );
      pack_sel = {b_hi, b_mid, b_lo};
   endfunction

   // Active-low enable of one on-board decoder bank.
   // The two banks share one request pin; the bank select opens only one of them at a time.
   function automatic logic bank_enable_n(
      input logic req,
      input logic bank,
      input logic want_bank
   );
      bank_enable_n = ~(req & (bank == want_bank));
   endfunction

   // Edge history of the conversion clock and the request.
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         conv_d_r <= 1'b0;
         req_d_r <= 1'b0;
      end else begin
         conv_d_r <= conversion_clock_1mhz;
         req_d_r <= analog_bus_request;
      end
   end

   // [RULE4] Timing taken from the conversion clock only.
   assign conv_rise = conversion_clock_1mhz & ~conv_d_r;
   assign req_fall = req_d_r & ~analog_bus_request;

   // [RULE4] Conversion edges seen while waiting; cleared whenever the machine is idle.
   // Counting only these edges means a stopped conversion clock holds the count still.
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         edge_cnt_r <= 8'h00;
      end else if (state_r == ISD_IDLE) begin
         edge_cnt_r <= 8'h00;
      end else if (state_r == ISD_WAIT && analog_bus_request && conv_rise) begin
         edge_cnt_r <= edge_cnt_r + 8'h01;
      end
   end

   // [RULE11] True while the next conversion edge completes the delay.
   assign last_edge = (edge_cnt_r + 8'h01 >= 8'(ENA_EDGES));

   // [RULE3] Delayed enable; a stopped clock leaves it waiting forever.
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         state_r <= ISD_IDLE;
      end else begin
         unique case (state_r)
            ISD_IDLE: begin
               if (analog_bus_request && !req_d_r) begin
                  state_r <= ISD_WAIT;
               end
            end
            ISD_WAIT: begin
               // [RULE11] Count two conversion edges, abort on request fall.
               if (!analog_bus_request) begin
                  state_r <= ISD_IDLE;
               end else if (conv_rise && last_edge) begin
                  state_r <= ISD_ENA;
               end
            end
            ISD_ENA: begin
               // [RULE11] Enable released as the request falls.
               if (req_fall || !analog_bus_request) begin
                  state_r <= ISD_IDLE;
               end
            end
            default: state_r <= ISD_IDLE;
         endcase
      end
   end

   // The strobe decoder adds one register stage, so strobes trail the enable by a cycle.
   assign sub_ena_n = (state_r != ISD_ENA);
   // Only four of the eight decoder outputs are used, so the top select bit is tied low.
   assign sub_sel = {1'b0, analog_target};

   // [RULE1] Sub-assembly strobe demultiplexer, one pulse per request.
   isd_dec3to8 u_sub_dec (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .enable_n(sub_ena_n),
      .sel(sub_sel),
      .out_n(sub_dec_n)
   );

   // [RULE8] Each write request yields one low pulse on its strobe.
   assign rf_assembly_strobe_n = sub_dec_n[`ISD_SUB_RF];
   assign freq_ctrl_assembly_strobe_n = sub_dec_n[`ISD_SUB_FC];
   assign if_assembly_strobe_n = sub_dec_n[`ISD_SUB_IF];
   assign logamp_assembly_strobe_n = sub_dec_n[`ISD_SUB_LOG];

   // [RULE2] Qualifier high while the frequency-control target is enabled.
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         freq_ctrl_strobe_qualifier <= 1'b0;
      end else begin
         freq_ctrl_strobe_qualifier <= (state_r == ISD_ENA) &&
            (analog_target == `ISD_SUB_FC);
      end
   end

   // [RULE7] Address and data buffered onto the control cable.
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         cable_addr <= 8'h00;
         cable_data <= 8'h00;
      end else begin
         cable_addr <= ctrl_addr;
         cable_data <= ctrl_data;
      end
   end

   // Decoder selects and bank enables; the first bank skips pin 0, the second skips pin 3.
   assign dec1_sel = pack_sel(iface_select_bit3, iface_select_bit2, iface_select_bit1);
   assign dec2_sel = pack_sel(iface_select_bit2, iface_select_bit1, iface_select_bit0);
   assign dec1_ena_n = bank_enable_n(iface_strobe_req, iface_bank_sel, 1'b0);
   assign dec2_ena_n = bank_enable_n(iface_strobe_req, iface_bank_sel, 1'b1);

   // [RULE5] First decoder on select bits 3..1.
   isd_dec3to8 u_dec1 (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .enable_n(dec1_ena_n),
      .sel(dec1_sel),
      .out_n(dec1_n)
   );

   // [RULE6] Second decoder on select bits 2..0.
   isd_dec3to8 u_dec2 (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .enable_n(dec2_ena_n),
      .sel(dec2_sel),
      .out_n(dec2_n)
   );

   // Codes 1, 5 and 6 of the first decoder drive nothing.
   assign keypad_scan_strobe_n = dec1_n[0];
   assign converter_load1_n = dec1_n[2];
   assign converter_load2_n = dec1_n[3];
   assign converter_load3_n = dec1_n[4];
   assign sampler_reg1_strobe_n = dec1_n[7];

   // Counter loads are active high, so those lines are inverted.
   assign keypad_sense_strobe_n = dec2_n[0];
   assign irq_priority_read_n = dec2_n[1];
   assign sampler_data1_read_n = dec2_n[2];
   assign converter_data0_strobe_n = dec2_n[3];
   assign counter_load0 = ~dec2_n[4];
   assign counter_load1 = ~dec2_n[5];
   assign knob_read_n = dec2_n[6];
   assign sampler_reg0_strobe_n = dec2_n[7];
endmodule

// *** sim/isd_strobe_decoder_props.sv ***
// Purpose: Port checks for the strobe decoder.
// Assumes: Selects and target held steady while asked for.
// Notes: Bound to every decoder instance.
`timescale 1ns/1ps
module isd_strobe_decoder_props (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic analog_bus_request,
   input wire logic conversion_clock_1mhz,
   input wire logic iface_strobe_req,
   input wire logic iface_bank_sel,
   input wire logic iface_select_bit0,
   input wire logic iface_select_bit1,
   input wire logic iface_select_bit2,
   input wire logic iface_select_bit3,
   input wire isd_pkg::isd_byte_t ctrl_data,
   input wire isd_pkg::isd_byte_t cable_data,
   input wire logic rf_assembly_strobe_n,
   input wire logic freq_ctrl_assembly_strobe_n,
   input wire logic if_assembly_strobe_n,
   input wire logic logamp_assembly_strobe_n,
   input wire logic knob_read_n,
   input wire logic freq_ctrl_strobe_qualifier,
   input wire logic converter_load1_n,
   input wire logic counter_load0,
   input wire logic keypad_scan_strobe_n
);
   import isd_pkg::*;

   // All checks sample on the system clock and stay quiet during reset.
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   // High while no sub-assembly strobe is active.
   wire sub_hi = rf_assembly_strobe_n & freq_ctrl_assembly_strobe_n
      & if_assembly_strobe_n & logamp_assembly_strobe_n;
   // Select codes as each on-board decoder sees them.
   wire [2:0] sel_lo = {iface_select_bit2, iface_select_bit1, iface_select_bit0};
   wire [2:0] sel_hi = {iface_select_bit3, iface_select_bit2, iface_select_bit1};

   fc_qual_a: assert property (!freq_ctrl_assembly_strobe_n
      |-> freq_ctrl_strobe_qualifier) else $error("qualifier missing");
   sub_delay_a: assert property ($rose(analog_bus_request)
      |=> sub_hi [*8]) else $error("strobe too early");
   conv_cause_a: assert property ($fell(sub_hi)
      |-> $past(conversion_clock_1mhz)) else $error("strobe without conversion clock");
   sub_req_a: assert property (!sub_hi
      |-> analog_bus_request || $past(analog_bus_request) || $past(analog_bus_request, 2))
      else $error("strobe without request");
   sub_release_a: assert property ($fell(analog_bus_request)
      |-> ##[1:3] sub_hi) else $error("strobe not released");
   dec_first_a: assert property (iface_strobe_req && !iface_bank_sel && sel_hi == 3'h2
      |=> !converter_load1_n) else $error("first decoder code");
   dec_second_a: assert property (iface_strobe_req && iface_bank_sel && sel_lo == 3'h4
      |=> counter_load0) else $error("second decoder code");
   dec_off_a: assert property (!iface_strobe_req
      |=> keypad_scan_strobe_n && knob_read_n && !counter_load0)
      else $error("decoder active while off");
   cable_copy_a: assert property ($past(rst_b)
      |-> cable_data == $past(ctrl_data)) else $error("cable data not copied");
endmodule
bind isd_strobe_decoder isd_strobe_decoder_props u_props (.*);

// *** sim/isd_ctrl_model.sv ***
// Purpose: Controller side conversion clock source.
// Assumes: 100 MHz system clock.
// Notes: Clock stands low while halted.
`timescale 1ns/1ps
module isd_ctrl_model (
   input wire logic clk_sys,
   input wire logic run,
   output logic conversion_clock_1mhz = 1'b0
);
   logic [5:0] cnt_r = '0;
   // One microsecond period from fifty system cycles per half.
   // Halting lets a scenario show that the delay never completes.
   always_ff @(posedge clk_sys) begin
      cnt_r <= (!run || cnt_r == 6'h31) ? 6'h00 : cnt_r + 6'h01;
      if (!run) conversion_clock_1mhz <= 1'b0;
      else if (cnt_r == 6'h31) conversion_clock_1mhz <= !conversion_clock_1mhz;
   end
endmodule

// *** sim/isd_strobe_decoder_tb.sv ***
// Purpose: Self-checking bench for the strobe decoder.
// Assumes: Conversion clock from the controller model.
// Notes: Unused first decoder codes are masked high.
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin mismatches++; \
   $display("ERROR %0t mismatch", $time); end end
module isd_strobe_decoder_tb;
   import isd_pkg::*;
   logic clk_sys = 0, rst_b = 0, req = 0, strb = 0, bank = 0, run = 1, conv, q;
   logic [1:0] tgt = 0;
   logic [3:0] sel = 0, sub_n;
   logic [7:0] o0, o1;
   isd_byte_t ad = 0, dt = 0, ca, cd;
   int mismatches = 0, cmp_count = 0;
   isd_ctrl_model u_ctrl (.clk_sys(clk_sys), .run(run), .conversion_clock_1mhz(conv));
   isd_strobe_decoder dut (.clk_sys(clk_sys), .rst_b(rst_b), .analog_bus_request(req),
      .conversion_clock_1mhz(conv), .analog_target(tgt), .iface_strobe_req(strb),
      .iface_bank_sel(bank), .iface_select_bit0(sel[0]), .iface_select_bit1(sel[1]),
      .iface_select_bit2(sel[2]), .iface_select_bit3(sel[3]), .ctrl_addr(ad),
      .ctrl_data(dt), .cable_addr(ca), .cable_data(cd), .rf_assembly_strobe_n(sub_n[0]),
      .freq_ctrl_assembly_strobe_n(sub_n[1]), .if_assembly_strobe_n(sub_n[2]),
      .logamp_assembly_strobe_n(sub_n[3]), .freq_ctrl_strobe_qualifier(q),
      .keypad_scan_strobe_n(o0[0]), .converter_load1_n(o0[2]), .converter_load2_n(o0[3]),
      .converter_load3_n(o0[4]), .sampler_reg1_strobe_n(o0[7]),
      .keypad_sense_strobe_n(o1[0]), .irq_priority_read_n(o1[1]),
      .sampler_data1_read_n(o1[2]), .converter_data0_strobe_n(o1[3]),
      .counter_load0(o1[4]), .counter_load1(o1[5]), .knob_read_n(o1[6]),
      .sampler_reg0_strobe_n(o1[7]));
   // Free-running system clock.
   initial forever #5 clk_sys = ~clk_sys;
   task automatic test_done;
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic t_sub(input logic [1:0] t);
      int n;
      n = 0;
      @(posedge clk_sys);
      tgt <= t;
      req <= 1'b1;
      do begin @(posedge clk_sys); #1 n++; end while (sub_n[t] !== 1'b0 && n < 400);
      `CHK(n >= 100 && n <= 210, 1'b1)
      `CHK(sub_n, ~(4'h1 << t))
      `CHK(q, t == 2'h1)
      @(posedge clk_sys);
      req <= 1'b0;
      repeat (3) @(posedge clk_sys);
      #1 `CHK(sub_n, 4'hf)
      $display("sub test %0d done", t);
   endtask
   task automatic t_noclk;
      @(posedge clk_sys);
      run <= 1'b0;
      req <= 1'b1;
      repeat (300) @(posedge clk_sys);
      #1 `CHK(sub_n, 4'hf)
      @(posedge clk_sys);
      req <= 1'b0;
      run <= 1'b1;
      repeat (3) @(posedge clk_sys);
      $display("no clock test done");
   endtask
   task automatic t_dec(input logic b);
      for (int c = 0; c < 8; c++) begin
         @(posedge clk_sys);
         strb <= 1'b1;
         bank <= b;
         sel <= b ? 4'(c) : 4'(c << 1);
         ad <= 8'(c);
         dt <= 8'(c * 37);
         repeat (2) @(posedge clk_sys);
         #1 `CHK({ca, cd}, {8'(c), 8'(c * 37)})
         if (b) `CHK(o1 ^ 8'h30, ~(8'h01 << c))
         else `CHK(o0 | 8'h62, ~(8'h01 << c) | 8'h62)
      end
      @(posedge clk_sys);
      strb <= 1'b0;
      repeat (2) @(posedge clk_sys);
      #1 `CHK({o0 | 8'h62, o1 ^ 8'h30}, 16'hffff)
      $display("decoder test %0d done", b);
   endtask
   // Main sequence after eight reset cycles.
   initial begin
      repeat (8) @(posedge clk_sys);
      rst_b <= 1'b1;
      for (int t = 0; t < 4; t++) t_sub(2'(t));
      t_noclk();
      t_dec(1'b0);
      t_dec(1'b1);
      test_done();
   end
   // Watchdog well beyond the expected run of about 11 us.
   initial begin
      #100us;
      mismatches++;
      test_done();
   end
endmodule
